// *** core/udc_params.svh ***
// Constants for the up/down counter relay
`ifndef UDC_PARAMS_SVH
`define UDC_PARAMS_SVH
`define UDC_CNT_W 32
`define UDC_CNT_MAX 32'sh7FFF_FFFF
`define UDC_CNT_MIN 32'sh8000_0000
`define UDC_CNT_ZERO 32'h0000_0000
`define UDC_NUM_CNT 32
`define UDC_RET_W 6
`define UDC_SCAN_US 1
`define UDC_CLK_MHZ 25
`define UDC_SCAN_CYC ((`UDC_SCAN_US * `UDC_CLK_MHZ) < 1 ? 1 : (`UDC_SCAN_US * `UDC_CLK_MHZ))
`endif

// *** core/udc_pkg.sv ***
// Types for the up/down counter relay
`default_nettype none
package udc_pkg;
    typedef struct packed {
        logic count_pulse_coil;
        logic direction_coil;
        logic clear_coil;
        logic preset_load_coil;
    } udc_coils_s;
    typedef struct packed {
        logic high_reached_flag;
        logic low_reached_flag;
        logic null_count_flag;
        logic wrap_flag;
    } udc_flags_s;
    typedef enum logic [2:0] {
        UDC_ST_STOP = 3'b001,
        UDC_ST_RUN = 3'b010,
        UDC_ST_HOLD = 3'b100
    } udc_state_e;
endpackage : udc_pkg
`default_nettype wire

// *** core/udc_counter_relay.sv ***
// Signed up/down counter relay with setpoint compare and retention
//
// Contract
// - Count one per rising count edge
// - Direction 0 counts up, 1 counts down
// - Clear forces zero, null flag active
// - Preset load edge loads preset value
// - Flags recomputed after preset load
// - Upper setpoint full signed 32-bit
// - Lower setpoint full signed 32-bit
// - Preset value full signed 32-bit
// - Actual count output signed 32-bit
// - Upward reaching upper setpoint sets high
// - Downward reaching lower setpoint sets low
// - Counting up drops null on leaving zero, low once above lower
// - Range excursion sets wrap, directional flags
// - Retentive count kept across stop, power
// - Retentive counter resumes from saved count
// - Retentive counter count is configurable
// - High flag when count >= upper
// - Low flag when count <= lower
// - Wrap one scan, count holds value
// - Count only in run mode
`include "udc_params.svh"
`default_nettype none
module udc_counter_relay
    import udc_pkg::*;
#(
    parameter logic [`UDC_RET_W-1:0] INDEX = 6'h00
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    // Mode and retention
    input wire logic run_mode_i,
    input wire logic power_fail_i,
    input wire logic [`UDC_RET_W-1:0] retentive_count_i,
    // Coils and parameters
    input wire udc_coils_s coils_i,
    input wire logic signed [`UDC_CNT_W-1:0] high_limit_i,
    input wire logic signed [`UDC_CNT_W-1:0] low_limit_i,
    input wire logic signed [`UDC_CNT_W-1:0] preset_value_i,
    // Results
    output logic signed [`UDC_CNT_W-1:0] actual_count_o,
    output udc_flags_s flags_o,
    output logic running_o
);
    //----------------------------------------
    // Input synchronisers and scan tick
    //----------------------------------------
    udc_coils_s sync1_reg, sync1_next, sync2_reg, sync2_next, prev_reg, prev_next;
    logic [1:0] run_sync_reg, run_sync_next, pf_sync_reg, pf_sync_next;
    logic [7:0] scan_cnt_reg, scan_cnt_next;
    logic scan_tick;

    assign scan_tick = (scan_cnt_reg == 8'h00);

    always_comb begin
        sync1_next = coils_i;
        sync2_next = sync1_reg;
        run_sync_next = {run_sync_reg[0], run_mode_i};
        pf_sync_next = {pf_sync_reg[0], power_fail_i};
        scan_cnt_next = scan_tick ? 8'(`UDC_SCAN_CYC - 1) : scan_cnt_reg - 8'h01;
        prev_next = scan_tick ? sync2_reg : prev_reg;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
            run_sync_reg <= 2'h0;
            pf_sync_reg <= 2'h0;
            scan_cnt_reg <= 8'h00;
        end else if (clk_en_i) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg <= prev_next;
            run_sync_reg <= run_sync_next;
            pf_sync_reg <= pf_sync_next;
            scan_cnt_reg <= scan_cnt_next;
        end
    end

    //----------------------------------------
    // Mode and count
    //----------------------------------------
    udc_state_e state_reg, state_next;
    logic signed [`UDC_CNT_W-1:0] count_reg, count_next;
    udc_flags_s flags_reg, flags_next;
    logic count_edge, load_edge, retentive, is_run;
    logic signed [`UDC_CNT_W:0] wide;
    logic ovf;

    assign count_edge = sync2_reg.count_pulse_coil & ~prev_reg.count_pulse_coil;
    assign load_edge = sync2_reg.preset_load_coil & ~prev_reg.preset_load_coil;
    assign retentive = (INDEX < retentive_count_i);
    assign is_run = (state_reg == UDC_ST_RUN);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        wide = '0;
        ovf = 1'b0;
        flags_next = flags_reg;
        case (state_reg)
            UDC_ST_STOP, UDC_ST_HOLD: begin
                if (run_sync_reg[1] && !pf_sync_reg[1]) begin
                    state_next = UDC_ST_RUN;
                    if (state_reg == UDC_ST_STOP && !retentive) begin
                        count_next = `UDC_CNT_ZERO;
                    end
                end
            end
            UDC_ST_RUN: begin
                if (!run_sync_reg[1] || pf_sync_reg[1]) begin
                    state_next = retentive ? UDC_ST_HOLD : UDC_ST_STOP;
                end
            end
            default: state_next = UDC_ST_STOP;
        endcase
        if (is_run && scan_tick) begin
            flags_next.wrap_flag = 1'b0;
            if (sync2_reg.clear_coil) begin
                count_next = `UDC_CNT_ZERO;
            end else if (load_edge) begin
                count_next = preset_value_i;
            end else if (count_edge) begin
                if (sync2_reg.direction_coil) begin
                    wide = {count_reg[`UDC_CNT_W-1], count_reg} - 33'sd1;
                end else begin
                    wide = {count_reg[`UDC_CNT_W-1], count_reg} + 33'sd1;
                end
                ovf = wide[`UDC_CNT_W] != wide[`UDC_CNT_W-1];
                if (ovf) begin
                    flags_next.wrap_flag = 1'b1;
                end else begin
                    count_next = wide[`UDC_CNT_W-1:0];
                end
            end
            // Flags follow the resulting count each scan
            flags_next.high_reached_flag = (count_next >= high_limit_i)
                || (ovf && !sync2_reg.direction_coil);
            flags_next.low_reached_flag = (count_next <= low_limit_i)
                || (ovf && sync2_reg.direction_coil);
            flags_next.null_count_flag = (count_next == `UDC_CNT_ZERO);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= UDC_ST_STOP;
            count_reg <= `UDC_CNT_ZERO;
            flags_reg <= '0;
        end else if (clk_en_i) begin
            state_reg <= state_next;
            count_reg <= count_next;
            flags_reg <= flags_next;
        end
    end

    //----------------------------------------
    // Registered outputs
    //----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            actual_count_o <= `UDC_CNT_ZERO;
            flags_o <= '0;
            running_o <= 1'b0;
        end else if (clk_en_i) begin
            actual_count_o <= count_next;
            flags_o <= flags_next;
            running_o <= (state_next == UDC_ST_RUN);
        end
    end

    //----------------------------------------
    // Checks
    //----------------------------------------
    sequence s_clear_scan;
        clk_en_i && is_run && scan_tick && sync2_reg.clear_coil;
    endsequence

    chk_clear_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_clear_scan |=> (count_reg == 0) && flags_reg.null_count_flag)
        else $error("clear did not zero count");
    chk_load_preset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && is_run && scan_tick && !sync2_reg.clear_coil && load_edge
        |=> count_reg == $past(preset_value_i))
        else $error("preset not loaded");
    chk_up_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && is_run && scan_tick && !sync2_reg.clear_coil && !load_edge && count_edge
        && !sync2_reg.direction_coil && count_reg != `UDC_CNT_MAX
        |=> count_reg == $past(count_reg) + 1)
        else $error("up count wrong");
    chk_down_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && is_run && scan_tick && !sync2_reg.clear_coil && !load_edge && count_edge
        && sync2_reg.direction_coil && count_reg != `UDC_CNT_MIN
        |=> count_reg == $past(count_reg) - 1)
        else $error("down count wrong");
    chk_no_run_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && !is_run |=> count_reg == $past(count_reg) || is_run)
        else $error("count moved outside run");
    chk_high_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && is_run && scan_tick && !flags_next.wrap_flag
        |=> flags_reg.high_reached_flag == (count_reg >= $past(high_limit_i)))
        else $error("high flag wrong");
    chk_low_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && is_run && scan_tick && !flags_next.wrap_flag
        |=> flags_reg.low_reached_flag == (count_reg <= $past(low_limit_i)))
        else $error("low flag wrong");
    chk_wrap_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && is_run && scan_tick && ovf
        |=> flags_reg.wrap_flag && count_reg == $past(count_reg))
        else $error("wrap did not hold count");
    chk_retain_stop: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i && state_reg == UDC_ST_HOLD |=> count_reg == $past(count_reg))
        else $error("retained count changed");
    chk_out_match: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        actual_count_o == count_reg)
        else $error("output differs from count");

    //----------------------------------------
    // Checks on scan order, mode and outputs
    //----------------------------------------
    logic run_scan;

    // Scan in which the coils act on the count
    assign run_scan = clk_en_i && is_run && scan_tick;

    sequence s_quiet_scan;
        run_scan && !sync2_reg.clear_coil && !load_edge && !count_edge;
    endsequence

    sequence s_all_coils_scan;
        run_scan && sync2_reg.clear_coil && load_edge && count_edge;
    endsequence

    sequence s_fresh_entry;
        clk_en_i && state_reg == UDC_ST_STOP && run_sync_reg[1] && !pf_sync_reg[1]
            && !retentive;
    endsequence

    sequence s_retentive_leave;
        clk_en_i && is_run && retentive && (!run_sync_reg[1] || pf_sync_reg[1]);
    endsequence

    sequence s_up_wrap;
        run_scan && ovf && !sync2_reg.direction_coil;
    endsequence

    sequence s_down_wrap;
        run_scan && ovf && sync2_reg.direction_coil;
    endsequence

    // Coil activity and flag renewal
    chk_quiet_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_quiet_scan |=> count_reg == $past(count_reg))
        else $error("count moved without a coil");
    chk_clear_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_all_coils_scan |=> count_reg == 0)
        else $error("clear lost against load or count");
    chk_preset_flags: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        run_scan && !sync2_reg.clear_coil && load_edge
        |=> flags_reg.high_reached_flag == (count_reg >= $past(high_limit_i))
            && flags_reg.low_reached_flag == (count_reg <= $past(low_limit_i)))
        else $error("flags not renewed after preset");
    chk_null_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        run_scan |=> flags_reg.null_count_flag == (count_reg == 0))
        else $error("null flag wrong");
    chk_wrap_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        run_scan && !ovf |=> !flags_reg.wrap_flag)
        else $error("wrap flag stood too long");
    chk_up_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_up_wrap |=> flags_reg.wrap_flag && flags_reg.high_reached_flag)
        else $error("upward wrap flags wrong");
    chk_down_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_down_wrap |=> flags_reg.wrap_flag && flags_reg.low_reached_flag)
        else $error("downward wrap flags wrong");

    // Mode changes and freezing
    chk_fresh_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_fresh_entry |=> is_run && count_reg == 0)
        else $error("fresh run did not start at zero");
    chk_retain_leave: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        s_retentive_leave |=> state_reg == UDC_ST_HOLD)
        else $error("retentive counter did not hold");
    chk_freeze_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !clk_en_i |=> count_reg == $past(count_reg) && state_reg == $past(state_reg)
            && flags_reg == $past(flags_reg))
        else $error("state moved while disabled");
    chk_scan_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        scan_cnt_reg <= 8'(`UDC_SCAN_CYC - 1))
        else $error("scan counter out of range");

    // Outputs mirror the registered state
    chk_flags_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        flags_o == flags_reg)
        else $error("flag output differs from flags");
    chk_running_out: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        running_o == is_run)
        else $error("running output differs from mode");
endmodule : udc_counter_relay
`default_nettype wire

// *** dv/udc_pulse_src.sv ***
// Pulse source and program logic model driving the count coil
`default_nettype none
module udc_pulse_src #(
    parameter int HALF = 60
) (
    // Clock and request
    input wire logic sys_clk_i,
    input wire logic [7:0] num_i,
    input wire logic go_i,
    // Pulse out
    output logic pulse_o,
    output logic busy_o
);
    int cyc = 0;
    logic [8:0] left = 9'h000;
    logic level = 1'b0;
    // ------------------------------
    // Square pulses, each level held for HALF clocks (60 by default, 2.4 scans of 25 clocks)
    // ------------------------------
    always @(negedge sys_clk_i) begin
        if (go_i && left == 9'h000) begin
            left <= {num_i, 1'b0};
            cyc <= 0;
        end else if (left != 9'h000) begin
            if (cyc == HALF - 1) begin
                level <= ~level;
                left <= left - 9'h001;
                cyc <= 0;
            end else begin
                cyc <= cyc + 1;
            end
        end
    end
    assign busy_o = (left != 9'h000);
    assign pulse_o = level;
endmodule : udc_pulse_src
`default_nettype wire

// *** dv/tb_up_down_counter_relay.sv ***
// Testbench for the up/down counter relay
`include "udc_params.svh"
`default_nettype none
module tb_up_down_counter_relay
    import udc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic clk_en = 1'b1;
    logic run_mode = 1'b0;
    logic power_fail = 1'b0;
    logic [5:0] ret_cnt = 6'h00;
    logic dir = 1'b0;
    logic clr = 1'b0;
    logic pld = 1'b0;
    logic go = 1'b0;
    logic [7:0] num = 8'h00;
    logic pulse;
    logic busy;
    logic running;
    logic signed [31:0] high_lim = 32'sh0000_0005;
    logic signed [31:0] low_lim = 32'sh0000_0002;
    logic signed [31:0] preset = 32'shFFFF_FFF9;
    logic signed [31:0] count;
    udc_coils_s coils;
    udc_flags_s flags;
    int num_errors = 0;
    int tests_run = 0;
    int wrap_cyc = 0;
    assign coils = {pulse, dir, clr, pld};
    always #20 sys_clk_i = ~sys_clk_i;
    always @(negedge sys_clk_i) if (flags.wrap_flag === 1'b1) wrap_cyc++;
    udc_counter_relay #(.INDEX(6'h00)) DUT (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
        .run_mode_i(run_mode), .power_fail_i(power_fail), .retentive_count_i(ret_cnt),
        .coils_i(coils), .high_limit_i(high_lim), .low_limit_i(low_lim),
        .preset_value_i(preset), .actual_count_o(count), .flags_o(flags), .running_o(running));
    udc_pulse_src #(.HALF(60)) SRC (
        .sys_clk_i(sys_clk_i), .num_i(num), .go_i(go), .pulse_o(pulse), .busy_o(busy));
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : wait_cyc
    task automatic chk_cnt(input string what, input logic signed [31:0] exp,
                           input logic signed [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt
    task automatic chk_flg(input string what, input udc_flags_s exp);
        tests_run++;
        if (flags !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, flags);
        end
    endtask : chk_flg
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic pulses(input logic [7:0] n);
        num <= n;
        go <= 1'b1;
        @(negedge sys_clk_i);
        go <= 1'b0;
        for (int k = 0; k < 4000 && (k < 2 || busy); k++) @(negedge sys_clk_i);
        if (busy) begin
            num_errors++;
            $display("BAD pulse source expected idle seen busy");
        end
        wait_cyc(80);
    endtask : pulses
    task automatic finish_test;
        $display("compares %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_count;
        run_mode <= 1'b1;
        wait_cyc(100);
        chk_cnt("entry count", 32'sh0000_0000, count);
        chk_flg("entry flags", 4'h6);
        pulses(8'h05);
        chk_cnt("up count", 32'sh0000_0005, count);
        chk_flg("up flags", 4'h8);
        dir <= 1'b1;
        pulses(8'h04);
        chk_cnt("down count", 32'sh0000_0001, count);
        chk_flg("down flags", 4'h4);
        $display("counting test done");
    endtask : t_count
    task automatic t_preset_clear;
        pld <= 1'b1;
        wait_cyc(80);
        pld <= 1'b0;
        wait_cyc(80);
        chk_cnt("preset count", 32'shFFFF_FFF9, count);
        chk_flg("preset flags", 4'h4);
        clr <= 1'b1;
        pld <= 1'b1;
        pulses(8'h01);
        chk_cnt("clear count", 32'sh0000_0000, count);
        chk_flg("clear flags", 4'h6);
        clr <= 1'b0;
        wait_cyc(80);
        pld <= 1'b0;
        wait_cyc(80);
        chk_cnt("after clear", 32'sh0000_0000, count);
        $display("preset and clear test done");
    endtask : t_preset_clear
    task automatic t_wrap;
        preset <= `UDC_CNT_MAX;
        high_lim <= 32'sh8000_0000;
        low_lim <= 32'sh8000_0000;
        dir <= 1'b0;
        pld <= 1'b1;
        wait_cyc(80);
        pld <= 1'b0;
        wait_cyc(80);
        chk_flg("top flags", 4'h8);
        wrap_cyc = 0;
        pulses(8'h01);
        chk_cnt("wrap count", `UDC_CNT_MAX, count);
        chk_cnt("wrap scans", `UDC_SCAN_CYC, wrap_cyc);
        chk_flg("wrap flags", 4'h8);
        preset <= `UDC_CNT_MIN;
        high_lim <= 32'sh0000_0005;
        dir <= 1'b1;
        pld <= 1'b1;
        wait_cyc(80);
        pld <= 1'b0;
        wait_cyc(80);
        chk_flg("bottom flags", 4'h4);
        wrap_cyc = 0;
        pulses(8'h01);
        chk_cnt("down wrap count", `UDC_CNT_MIN, count);
        chk_cnt("down wrap scans", `UDC_SCAN_CYC, wrap_cyc);
        chk_flg("down wrap flags", 4'h4);
        $display("wrap test done");
    endtask : t_wrap
    task automatic t_mode;
        run_mode <= 1'b0;
        dir <= 1'b1;
        wait_cyc(100);
        chk_bit("stop running", 1'b0, running);
        pulses(8'h02);
        chk_cnt("stop count", `UDC_CNT_MIN, count);
        dir <= 1'b0;
        run_mode <= 1'b1;
        wait_cyc(100);
        chk_bit("restart running", 1'b1, running);
        chk_cnt("restart count", 32'sh0000_0000, count);
        ret_cnt <= 6'h01;
        pulses(8'h03);
        power_fail <= 1'b1;
        wait_cyc(100);
        chk_bit("supply loss running", 1'b0, running);
        chk_cnt("supply loss count", 32'sh0000_0003, count);
        power_fail <= 1'b0;
        run_mode <= 1'b0;
        wait_cyc(100);
        run_mode <= 1'b1;
        wait_cyc(100);
        pulses(8'h01);
        chk_cnt("retained count", 32'sh0000_0004, count);
        $display("mode test done");
    endtask : t_mode
    task automatic t_freeze_reset;
        clk_en <= 1'b0;
        pulses(8'h02);
        clk_en <= 1'b1;
        wait_cyc(80);
        chk_cnt("frozen count", 32'sh0000_0004, count);
        pulses(8'h01);
        chk_cnt("thawed count", 32'sh0000_0005, count);
        rst_i <= 1'b1;
        wait_cyc(2);
        chk_cnt("reset count", 32'sh0000_0000, count);
        chk_flg("reset flags", 4'h0);
        chk_bit("reset running", 1'b0, running);
        rst_i <= 1'b0;
        wait_cyc(100);
        chk_bit("after reset running", 1'b1, running);
        chk_flg("after reset flags", 4'h2);
        $display("freeze and reset test done");
    endtask : t_freeze_reset
    initial begin
        wait_cyc(12);
        rst_i <= 1'b0;
        t_count();
        t_preset_clear();
        t_wrap();
        t_mode();
        t_freeze_reset();
        finish_test();
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        finish_test();
    end
endmodule : tb_up_down_counter_relay
`default_nettype wire
